// ==== rtl/qsf_fault_top.sv ====
// qsf_fault_top: fault reporting and protection control, four channels
// assumes analog flags arrive asynchronous and active high; pins are
// split into input, output and output enable, the bench resolves wires
//
// Function
// - variant a: per-channel active-low status pulled low on reportable fault.
// - variant b: global active-low alarm low when any channel faults.
// - variant b: selected faulted channel forces sense output to fault-high.
// - commanded-on channel reports overcurrent at internal or external limit.
// - overcurrent report clears by itself when overcurrent goes away.
// - on-state open load never reaches status or alarm outputs.
// - commanded-off channel with output near supply reports a fault.
// - short-to-battery and reverse polarity behave exactly as open load.
// - thermal fault state kept separately per channel.
// - overtemperature turns that channel's output off.
// - latch-select low: auto-retry, reduced limit, clear on reset temp or toggle.
// - latch-select high: latch off, clear only on command toggle.
// - latch-select falling switches thermal handling to auto-retry.
// - thermal swing turns output off, restores and clears automatically.
// - undervoltage shuts all outputs until supply recovers.
// - ground or supply loss forces every output off.
// - normal, standby, standby-diagnostics modes; standby after long low commands.
// - diagnostics disabled: outputs high impedance, protection only for on channels.
// - select 00/01/10/11 picks channel one to four for sense.
`timescale 1ns/1ps
module qsf_fault_top #(
  parameter int unsigned NUM_CH = qsf_pkg::NUM_CH,
  parameter int unsigned SENSE_W = qsf_pkg::SENSE_W,
  parameter int unsigned STBY_DEGLITCH_CYC = qsf_pkg::STBY_DEGLITCH_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // host pins
  input wire logic [NUM_CH-1:0] channel_command,
  input wire logic diagnostics_enable,
  input wire logic overheat_latch_choice,
  input wire logic sense_pick_msb,
  input wire logic sense_pick_lsb,
  // variant choice, a static strap: high selects the current-sense variant
  input wire logic variant_sense,
  // analog flags per channel
  input wire logic [NUM_CH-1:0] overcurrent_int,
  input wire logic [NUM_CH-1:0] overcurrent_ext,
  input wire logic [NUM_CH-1:0] offstate_near_supply,
  input wire logic [NUM_CH-1:0] overheat,
  input wire logic [NUM_CH-1:0] overheat_hys_ok,
  input wire logic [NUM_CH-1:0] overheat_clear_temperature,
  input wire logic [NUM_CH-1:0] thermal_swing,
  // global analog flags
  input wire logic supply_undervoltage,
  input wire logic ground_lost,
  input wire logic supply_lost,
  // load current per channel, already digitised
  input wire logic [NUM_CH*SENSE_W-1:0] load_current,
  // power stage
  output logic [NUM_CH-1:0] switch_on,
  output logic [NUM_CH-1:0] reduced_current_limit,
  // per-channel status, open drain
  output logic [NUM_CH-1:0] channel_alarm_n_o,
  output logic [NUM_CH-1:0] channel_alarm_n_oe,
  // global alarm, open drain
  output logic global_alarm_n_o,
  output logic global_alarm_n_oe,
  // sense output
  output logic [SENSE_W-1:0] sense_value,
  output logic sense_oe,
  // mode
  output qsf_pkg::qsf_mode_t mode
);
  localparam int unsigned FLAG_W = 7 * NUM_CH + 3;
  localparam int unsigned PIN_W = NUM_CH + 5;
  localparam int unsigned CNT_W = $clog2(STBY_DEGLITCH_CYC + 1);

  // =====================================
  // input synchronisation
  logic [FLAG_W-1:0] flag_raw, flag_s;
  logic [PIN_W-1:0] pin_raw, pin_s;
  logic [NUM_CH-1:0] oc_s, ocx_s, ol_s, ot_s, hys_s, rst_s, sw_s, cmd_s;
  logic uv_s, gl_s, sl_s, diag_s, latch_s, msb_s, lsb_s, var_s;

  assign flag_raw = {overcurrent_int, overcurrent_ext, offstate_near_supply, overheat, overheat_hys_ok,
                     overheat_clear_temperature, thermal_swing, supply_undervoltage, ground_lost, supply_lost};
  assign pin_raw = {channel_command, diagnostics_enable, overheat_latch_choice, sense_pick_msb, sense_pick_lsb,
                    variant_sense};

  qsf_sync #(.WIDTH(FLAG_W)) u_flag_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .async_in(flag_raw),
    .sync_out(flag_s)
  );
  qsf_sync #(.WIDTH(PIN_W)) u_pin_sync (
    .core_clk(core_clk),
    .resetn(resetn),
    .async_in(pin_raw),
    .sync_out(pin_s)
  );

  assign {oc_s, ocx_s, ol_s, ot_s, hys_s, rst_s, sw_s, uv_s, gl_s, sl_s} = flag_s;
  assign {cmd_s, diag_s, latch_s, msb_s, lsb_s, var_s} = pin_s;

  // =====================================
  // edge detection on sampled pins
  logic [NUM_CH-1:0] cmd_prev_q;
  logic latch_prev_q;
  logic [NUM_CH-1:0] cmd_toggle;
  logic latch_fall;

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      cmd_prev_q <= '0;
      latch_prev_q <= 1'b0;
    end
    else
    begin
      cmd_prev_q <= cmd_s;
      latch_prev_q <= latch_s;
    end
  end

  assign cmd_toggle = cmd_s ^ cmd_prev_q;
  assign latch_fall = latch_prev_q && !latch_s;

  // =====================================
  // global protection
  // undervoltage, ground and supply loss each override every command
  logic global_kill;
  assign global_kill = uv_s || gl_s || sl_s;

  // =====================================
  // per-channel fault handling
  logic [NUM_CH-1:0] therm_off, therm_fault, chan_fault, gate_d;
  logic [NUM_CH-1:0] switch_on_q, rcl_q;
  logic [NUM_CH-1:0] therm_rcl;

  for (genvar ch = 0; ch < NUM_CH; ch++)
  begin : g_ch
    // protection runs only while commanded on when diagnostics are off
    logic prot_active;
    logic oc_fault, ol_fault;
    assign prot_active = diag_s || cmd_s[ch];

    qsf_therm u_therm (
      .core_clk(core_clk),
      .resetn(resetn),
      .overheat(ot_s[ch] && prot_active),
      .overheat_hys_ok(hys_s[ch]),
      .overheat_clear_temperature(rst_s[ch]),
      .swing(sw_s[ch] && prot_active),
      .latch_mode(latch_s),
      .latch_fall(latch_fall),
      .cmd_toggle(cmd_toggle[ch]),
      .gate_off(therm_off[ch]),
      .reduced_current_limit(therm_rcl[ch]),
      .therm_fault(therm_fault[ch])
    );

    // overcurrent is combinational on live flags, so it clears itself
    assign oc_fault = cmd_s[ch] && (oc_s[ch] || ocx_s[ch]);
    // comparator also fires for short-to-battery and reverse polarity
    assign ol_fault = !cmd_s[ch] && ol_s[ch];
    // on-state open load has no flag input here, so it never reaches the alarms
    assign chan_fault[ch] = oc_fault || ol_fault || therm_fault[ch];
    assign gate_d[ch] = cmd_s[ch] && !therm_off[ch] && !global_kill;
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      switch_on_q <= '0;
      rcl_q <= '0;
    end
    else
    begin
      switch_on_q <= gate_d;
      rcl_q <= therm_rcl;
    end
  end

  assign switch_on = switch_on_q;
  assign reduced_current_limit = rcl_q;

  // =====================================
  // working mode
  logic [CNT_W-1:0] idle_cnt_q, idle_cnt_d;
  qsf_pkg::qsf_mode_t mode_q, mode_d;
  logic all_low, idle_done;

  assign all_low = cmd_s == '0;
  assign idle_done = idle_cnt_q == CNT_W'(STBY_DEGLITCH_CYC);
  assign idle_cnt_d = !all_low ? '0 : (idle_done ? idle_cnt_q : idle_cnt_q + CNT_W'(1));

  always_comb
  begin
    mode_d = mode_q;
    case (mode_q)
      qsf_pkg::QSF_MODE_NORMAL:
        if (idle_done)
          mode_d = diag_s ? qsf_pkg::QSF_MODE_STANDBY_DIAG : qsf_pkg::QSF_MODE_STANDBY;
      qsf_pkg::QSF_MODE_STANDBY:
        if (!all_low)
          mode_d = qsf_pkg::QSF_MODE_NORMAL;
        else if (diag_s)
          mode_d = qsf_pkg::QSF_MODE_STANDBY_DIAG;
      qsf_pkg::QSF_MODE_STANDBY_DIAG:
        if (!all_low)
          mode_d = qsf_pkg::QSF_MODE_NORMAL;
        else if (!diag_s)
          mode_d = qsf_pkg::QSF_MODE_STANDBY;
      default:
        mode_d = qsf_pkg::QSF_MODE_NORMAL;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      idle_cnt_q <= '0;
      mode_q <= qsf_pkg::QSF_MODE_NORMAL;
    end
    else
    begin
      idle_cnt_q <= idle_cnt_d;
      mode_q <= mode_d;
    end
  end

  assign mode = mode_q;

  // =====================================
  // reporting outputs
  // standby without diagnostics also leaves every report floating
  logic report_en;
  logic [1:0] pick;
  logic [SENSE_W-1:0] picked_current;
  logic picked_fault;
  logic [NUM_CH-1:0] alarm_oe_q;
  logic global_oe_q;
  logic [SENSE_W-1:0] sense_q;
  logic sense_oe_q;

  assign report_en = diag_s && mode_q != qsf_pkg::QSF_MODE_STANDBY;
  assign pick = {msb_s, lsb_s};
  assign picked_current = pick == qsf_pkg::SEL_CH1 ? load_current[0*SENSE_W +: SENSE_W]
                        : pick == qsf_pkg::SEL_CH2 ? load_current[1*SENSE_W +: SENSE_W]
                        : pick == qsf_pkg::SEL_CH3 ? load_current[2*SENSE_W +: SENSE_W]
                        : load_current[3*SENSE_W +: SENSE_W];
  assign picked_fault = chan_fault[pick];

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      alarm_oe_q <= '0;
      global_oe_q <= 1'b0;
      sense_q <= qsf_pkg::SENSE_ZERO;
      sense_oe_q <= 1'b0;
    end
    else
    begin
      alarm_oe_q <= (report_en && !var_s) ? chan_fault : '0;
      global_oe_q <= report_en && var_s && (chan_fault != '0);
      sense_q <= picked_fault ? qsf_pkg::SENSE_FAULT_HIGH
               : (cmd_s[pick] ? picked_current : qsf_pkg::SENSE_ZERO);
      sense_oe_q <= report_en && var_s;
    end
  end

  // open drain alarms only ever drive low; sense drives both levels
  assign channel_alarm_n_o = '0;
  assign channel_alarm_n_oe = alarm_oe_q;
  assign global_alarm_n_o = 1'b0;
  assign global_alarm_n_oe = global_oe_q;
  assign sense_value = sense_q;
  assign sense_oe = sense_oe_q;
endmodule

// ==== include/qsf_pkg.sv ====
// qsf_pkg: shared constants for the quad switch fault logic
// assumes a 100 MHz core_clk; no bus, all control is on plain ports
package qsf_pkg;
  localparam int unsigned NUM_CH = 4;
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned CLK_PERIOD_NS = 10;
  // standby deglitch time; no figure is given, so this is a plain default
  localparam int unsigned STBY_DEGLITCH_US = 1000;
  localparam int unsigned STBY_DEGLITCH_CYC = STBY_DEGLITCH_US * CLK_MHZ;
  localparam int unsigned SENSE_W = 8;
  // =====================================
  // sense output codes
  localparam logic [7:0] SENSE_FAULT_HIGH = 8'hFF;
  localparam logic [7:0] SENSE_ZERO = 8'h00;
  // =====================================
  // sense channel select codes
  localparam logic [1:0] SEL_CH1 = 2'h0;
  localparam logic [1:0] SEL_CH2 = 2'h1;
  localparam logic [1:0] SEL_CH3 = 2'h2;
  localparam logic [1:0] SEL_CH4 = 2'h3;
  typedef enum logic [1:0] {
    QSF_MODE_NORMAL = 2'b00,
    QSF_MODE_STANDBY = 2'b01,
    QSF_MODE_STANDBY_DIAG = 2'b10
  } qsf_mode_t;
  typedef enum logic [1:0] {
    QSF_TH_OK = 2'b00,
    QSF_TH_SHUT = 2'b01,
    QSF_TH_RETRY = 2'b10,
    QSF_TH_LATCHED = 2'b11
  } qsf_therm_t;
endpackage

// ==== rtl/qsf_sync.sv ====
// qsf_sync: two flip-flop synchroniser for a vector of levels
// assumes async inputs; reset value is zero
`timescale 1ns/1ps
module qsf_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // data
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_q;
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      meta_q <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule

// ==== rtl/qsf_therm.sv ====
// qsf_therm: per-channel thermal shutdown and thermal swing handling
// assumes synchronised flags and a one-cycle command toggle pulse
`timescale 1ns/1ps
module qsf_therm (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // conditions
  input wire logic overheat,
  input wire logic overheat_hys_ok,
  input wire logic overheat_clear_temperature,
  input wire logic swing,
  input wire logic latch_mode,
  input wire logic latch_fall,
  input wire logic cmd_toggle,
  // results
  output logic gate_off,
  output logic reduced_current_limit,
  output logic therm_fault
);
  qsf_pkg::qsf_therm_t st_q, st_d;
  logic fault_q, fault_d;
  logic swing_q;

  // =====================================
  // shutdown state
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      qsf_pkg::QSF_TH_OK:
        if (overheat)
          st_d = latch_mode ? qsf_pkg::QSF_TH_LATCHED : qsf_pkg::QSF_TH_SHUT;
      qsf_pkg::QSF_TH_SHUT:
        if (latch_mode && !overheat)
          st_d = qsf_pkg::QSF_TH_LATCHED;
        else if (overheat_hys_ok)
          st_d = qsf_pkg::QSF_TH_RETRY;
      qsf_pkg::QSF_TH_RETRY:
        if (overheat)
          st_d = latch_mode ? qsf_pkg::QSF_TH_LATCHED : qsf_pkg::QSF_TH_SHUT;
        else if (cmd_toggle || overheat_clear_temperature)
          st_d = qsf_pkg::QSF_TH_OK;
      qsf_pkg::QSF_TH_LATCHED:
        if (cmd_toggle)
          st_d = qsf_pkg::QSF_TH_OK;
        else if (latch_fall)
          st_d = qsf_pkg::QSF_TH_SHUT;
      default:
        st_d = qsf_pkg::QSF_TH_OK;
    endcase
  end

  // fault report: set wins over clear in the same cycle
  always_comb
  begin
    fault_d = fault_q;
    if ((cmd_toggle || (!latch_mode && overheat_clear_temperature)) && st_q != qsf_pkg::QSF_TH_SHUT)
      fault_d = 1'b0;
    if (overheat)
      fault_d = 1'b1;
  end

  always_ff @(posedge core_clk)
  begin
    if (!resetn)
    begin
      st_q <= qsf_pkg::QSF_TH_OK;
      fault_q <= 1'b0;
      swing_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      fault_q <= fault_d;
      swing_q <= swing;
    end
  end

  // swing fault self clears once the flag drops below hysteresis
  assign gate_off = overheat || swing || st_q == qsf_pkg::QSF_TH_SHUT || st_q == qsf_pkg::QSF_TH_LATCHED;
  assign reduced_current_limit = st_q == qsf_pkg::QSF_TH_RETRY;
  assign therm_fault = fault_q || swing_q;
endmodule

// ==== tb/qsf_fault_top_assertions.sv ====
// checker for qsf_fault_top, bound to its ports
// assumes 3 edges from pin to output; flags held 4 edges
`timescale 1ns/1ps
module qsf_fault_top_chk #(
  parameter int unsigned NUM_CH = 4,
  parameter int unsigned SENSE_W = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  // host pins
  input wire logic [NUM_CH-1:0] channel_command,
  input wire logic diagnostics_enable,
  input wire logic sense_pick_msb,
  input wire logic sense_pick_lsb,
  input wire logic variant_sense,
  // flags
  input wire logic [NUM_CH-1:0] overcurrent_int,
  input wire logic [NUM_CH-1:0] offstate_near_supply,
  input wire logic [NUM_CH-1:0] overheat,
  input wire logic supply_undervoltage,
  input wire logic ground_lost,
  input wire logic supply_lost,
  // outputs
  input wire logic [NUM_CH-1:0] switch_on,
  input wire logic [NUM_CH-1:0] channel_alarm_n_oe,
  input wire logic global_alarm_n_oe,
  input wire logic [SENSE_W-1:0] sense_value,
  input wire logic sense_oe
);
  // ========
  // settling after reset
  // synchronisers hold zero for a few edges, so skip them
  logic [2:0] up_q;
  logic [2:0] up_d;
  logic rdy;
  logic ok;
  assign up_d = rdy ? up_q : up_q + 3'h1;
  assign rdy = up_q == 3'h7;
  assign ok = rdy && diagnostics_enable && !supply_undervoltage && !ground_lost && !supply_lost;
  always_ff @(posedge core_clk)
  begin
    if (!resetn)
      up_q <= 3'h0;
    else
      up_q <= up_d;
  end
  // ========
  // properties
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  sequence s_oc0;
    ok && !variant_sense && channel_command[0] && overcurrent_int[0];
  endsequence
  AST_LOSS_OFF:
    assert property ((rdy && (ground_lost || supply_lost))[*4] |-> switch_on == '0)
      else $error("output on during ground or supply loss");
  AST_UV_OFF:
    assert property ((rdy && supply_undervoltage)[*4] |-> switch_on == '0)
      else $error("output on during undervoltage");
  AST_DIAG_OFF:
    assert property ((rdy && !diagnostics_enable)[*4] |-> !sense_oe && !global_alarm_n_oe && channel_alarm_n_oe == '0)
      else $error("report pins driven with diagnostics off");
  AST_OC_STATUS:
    assert property (s_oc0[*4] |-> channel_alarm_n_oe[0])
      else $error("overcurrent not on status pin");
  AST_GLOBAL:
    assert property ((ok && variant_sense && channel_command[2] && overcurrent_int[2])[*4] |-> global_alarm_n_oe)
      else $error("global alarm missing");
  AST_SENSE_HIGH:
    assert property ((ok && variant_sense && sense_pick_msb && !sense_pick_lsb && channel_command[2]
      && overcurrent_int[2])[*4] |-> sense_value == qsf_pkg::SENSE_FAULT_HIGH)
      else $error("sense not at fault level");
  AST_OPEN_OFF:
    assert property ((ok && !variant_sense && !channel_command[3] && channel_command[0]
      && offstate_near_supply[3])[*4] |-> channel_alarm_n_oe[3])
      else $error("off-state open load not reported");
  AST_OVH_OFF:
    assert property ((rdy && overheat[0])[*4] |-> !switch_on[0])
      else $error("output on during overheat");
endmodule
bind qsf_fault_top qsf_fault_top_chk #(.NUM_CH(NUM_CH), .SENSE_W(SENSE_W)) u_chk (.*);

// ==== tb/qsf_host_model.sv ====
// qsf_host_model: host side of the status, alarm and sense pins
// assumes pull-ups on open-drain lines and an adc on sense
`timescale 1ns/1ps
module qsf_host_model (
  // clock
  input wire logic core_clk,
  // device pins
  input wire logic [3:0] channel_alarm_n_o,
  input wire logic [3:0] channel_alarm_n_oe,
  input wire logic global_alarm_n_o,
  input wire logic global_alarm_n_oe,
  input wire logic [7:0] sense_value,
  input wire logic sense_oe,
  // levels seen by the host
  output logic [3:0] status_n,
  output logic fault_n,
  output logic [7:0] adc_q
);
  // released lines go to the pull-up level
  assign status_n = channel_alarm_n_o | ~channel_alarm_n_oe;
  assign fault_n = global_alarm_n_o | ~global_alarm_n_oe;
  // floating sense has no pull, so the reading wanders
  always_ff @(posedge core_clk)
    adc_q <= sense_oe ? sense_value : ~adc_q;
endmodule

// ==== tb/qsf_fault_top_test.sv ====
// qsf_fault_top_test: directed pin-level tests of the fault logic
// assumes the host model resolves pins; short standby deglitch
`timescale 1ns/1ps
module qsf_fault_top_test;
  // ========
  // nets
  logic core_clk, resetn, diagnostics_enable, overheat_latch_choice, sense_pick_msb, sense_pick_lsb;
  logic variant_sense, supply_undervoltage, ground_lost, supply_lost;
  logic [3:0] channel_command, overcurrent_int, overcurrent_ext, offstate_near_supply, overheat;
  logic [3:0] overheat_hys_ok, overheat_clear_temperature, thermal_swing;
  logic [31:0] load_current;
  logic [3:0] switch_on, reduced_current_limit, channel_alarm_n_o, channel_alarm_n_oe, status_n;
  logic global_alarm_n_o, global_alarm_n_oe, sense_oe, fault_n;
  logic [7:0] sense_value, adc_q;
  qsf_pkg::qsf_mode_t mode;
  int err_total;
  int n_compared;
  qsf_fault_top #(.STBY_DEGLITCH_CYC(20)) uut (.*);
  qsf_host_model host (.*);
  // ========
  // tasks
  task automatic go;
    @(posedge core_clk);
  endtask
  task automatic settle;
    repeat (6) @(negedge core_clk);
  endtask
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test;
    $display("compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ========
  // clock and watchdog
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial
  begin
    repeat (3000) @(posedge core_clk);
    err_total++;
    $display("unexpected at %0t: watchdog expired", $time);
    stop_test;
  end
  // ========
  // tests
  initial
  begin
    err_total = 0;
    n_compared = 0;
    {resetn, overheat_latch_choice, sense_pick_msb, sense_pick_lsb, variant_sense} = '0;
    {supply_undervoltage, ground_lost, supply_lost} = '0;
    {overcurrent_int, overcurrent_ext, offstate_near_supply, overheat} = '0;
    {overheat_hys_ok, overheat_clear_temperature, thermal_swing} = '0;
    channel_command = 4'hF;
    diagnostics_enable = 1'b1;
    load_current = 32'h44332211;
    repeat (10) go;
    resetn <= 1'b1;
    settle;
    check(status_n, 4'hF);
    check(switch_on, 4'hF);
    go;
    overcurrent_int[0] <= 1'b1;
    settle;
    check(status_n, 4'hE);
    go;
    overcurrent_int[0] <= 1'b0;
    overcurrent_ext[1] <= 1'b1;
    settle;
    check(status_n, 4'hD);
    go;
    overcurrent_ext[1] <= 1'b0;
    variant_sense <= 1'b1;
    overcurrent_int[2] <= 1'b1;
    settle;
    check(fault_n, 1'b0);
    for (int s = 0; s < 4; s++)
    begin
      go;
      {sense_pick_msb, sense_pick_lsb} <= 2'(s);
      settle;
      check(adc_q, (s == 2) ? 8'hFF : load_current[8*s +: 8]);
    end
    go;
    overcurrent_int[2] <= 1'b0;
    settle;
    check(fault_n, 1'b1);
    $display("test reporting done");
    go;
    variant_sense <= 1'b0;
    channel_command[3] <= 1'b0;
    offstate_near_supply[3] <= 1'b1;
    settle;
    check(status_n, 4'h7);
    go;
    channel_command[3] <= 1'b1;
    settle;
    check(status_n, 4'hF);
    $display("test open load done");
    go;
    offstate_near_supply[3] <= 1'b0;
    overheat[0] <= 1'b1;
    settle;
    check(switch_on, 4'hE);
    check(status_n, 4'hE);
    go;
    overheat[0] <= 1'b0;
    overheat_hys_ok[0] <= 1'b1;
    settle;
    check(switch_on, 4'hF);
    check(reduced_current_limit[0], 1'b1);
    check(status_n, 4'hE);
    go;
    overheat_clear_temperature[0] <= 1'b1;
    settle;
    check(status_n, 4'hF);
    go;
    overheat_latch_choice <= 1'b1;
    overheat[1] <= 1'b1;
    settle;
    go;
    overheat[1] <= 1'b0;
    overheat_hys_ok[1] <= 1'b1;
    settle;
    check(switch_on, 4'hD);
    check(status_n, 4'hD);
    go;
    channel_command[1] <= 1'b0;
    go;
    channel_command[1] <= 1'b1;
    settle;
    check(switch_on, 4'hF);
    check(status_n, 4'hF);
    go;
    overheat[2] <= 1'b1;
    settle;
    go;
    overheat[2] <= 1'b0;
    overheat_hys_ok[2] <= 1'b1;
    settle;
    check(switch_on, 4'hB);
    go;
    overheat_latch_choice <= 1'b0;
    settle;
    check(switch_on, 4'hF);
    go;
    overheat_clear_temperature <= 4'hF;
    settle;
    check(status_n, 4'hF);
    $display("test thermal done");
    go;
    thermal_swing[3] <= 1'b1;
    settle;
    check(switch_on, 4'h7);
    check(status_n, 4'h7);
    go;
    thermal_swing[3] <= 1'b0;
    settle;
    check(switch_on, 4'hF);
    check(status_n, 4'hF);
    for (int k = 0; k < 3; k++)
    begin
      go;
      {supply_undervoltage, ground_lost, supply_lost} <= 3'h4 >> k;
      settle;
      check(switch_on, 4'h0);
    end
    go;
    {supply_undervoltage, ground_lost, supply_lost} <= 3'h0;
    settle;
    check(switch_on, 4'hF);
    $display("test protection done");
    go;
    diagnostics_enable <= 1'b0;
    overcurrent_int[0] <= 1'b1;
    settle;
    check(status_n, 4'hF);
    go;
    channel_command <= 4'h0;
    overcurrent_int[0] <= 1'b0;
    repeat (30) @(negedge core_clk);
    check(mode, qsf_pkg::QSF_MODE_STANDBY);
    go;
    diagnostics_enable <= 1'b1;
    settle;
    check(mode, qsf_pkg::QSF_MODE_STANDBY_DIAG);
    go;
    channel_command[0] <= 1'b1;
    settle;
    check(mode, qsf_pkg::QSF_MODE_NORMAL);
    $display("test modes done");
    stop_test;
  end
endmodule
